// File: design/tsr_regs.sv
`timescale 1ns/1ps

module tsr_regs
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // thread load from the dispatcher
    input  wire logic        load_valid,
    input  wire logic [47:0] load_scratch_ptr,
    input  wire logic [47:0] load_scratch_size,
    input  wire logic [47:0] load_stack_limit,
    input  wire logic [127:0] load_state,
    input  wire logic        load_flat,
    // instruction register access
    input  wire logic        acc_valid,
    input  wire logic        acc_write,
    input  wire logic [7:0]  acc_regnum,
    input  wire logic [4:0]  acc_subreg,
    input  wire logic [1:0]  acc_size,
    input  wire logic [63:0] acc_wdata,
    input  wire logic        acc_switch,
    input  wire logic        acc_flat,
    output logic      [63:0] acc_rdata,
    output logic             acc_rvalid,
    output logic             acc_error,
    // stack store message
    input  wire logic        stk_store,
    output logic      [47:0] msg_sp,
    output logic             msg_sp_valid,
    output logic             msg_sp_flat,
    // exception
    output logic             sp_exception
);

    logic [47:0]  cur_sp_r;
    logic [47:0]  limit_r;
    logic [47:0]  base_r;
    logic         flat_r;
    logic [31:0]  st_r [tsr_pkg::ST_WORDS];

    // -----------------------------------------------------------------
    // decode
    // -----------------------------------------------------------------
    logic         is_sp;
    logic         is_st;
    logic         sel_cur;
    logic         sel_lim;
    logic         sel_st;
    logic         hi_dw;
    logic [1:0]   st_idx;
    logic [1:0]   st_byte;

    assign is_sp   = acc_regnum == {tsr_pkg::TYPE_STACK_PTR,
                                    tsr_pkg::REGNUM_ZERO};
    assign is_st   = acc_regnum == {tsr_pkg::TYPE_THREAD_ST,
                                    tsr_pkg::REGNUM_ZERO};
    assign hi_dw   = acc_size == tsr_pkg::SIZE_DWORD
                     && acc_subreg[1:0] == 2'h0
                     && acc_subreg[2];
    // dword aliases inside a qword: 0/4 -> pointer, 8/12 -> limit
    assign sel_cur = is_sp && ((acc_subreg == tsr_pkg::SUB_CUR_SP)
                     || (acc_size == tsr_pkg::SIZE_DWORD
                         && acc_subreg == tsr_pkg::SUB_ST_WORD1));
    assign sel_lim = is_sp && ((acc_subreg == tsr_pkg::SUB_LIMIT)
                     || (acc_size == tsr_pkg::SIZE_DWORD
                         && acc_subreg == tsr_pkg::SUB_ST_WORD3));
    assign st_idx  = acc_subreg[3:2];
    assign st_byte = acc_subreg[1:0];
    assign sel_st  = is_st && !acc_subreg[4]
                     && (acc_size == tsr_pkg::SIZE_BYTE
                         || (acc_size == tsr_pkg::SIZE_DWORD
                             && st_byte == 2'h0));

    logic         sp_size_ok;
    logic         acc_ok;
    assign sp_size_ok = acc_size == tsr_pkg::SIZE_DWORD
                        || acc_size == tsr_pkg::SIZE_QWORD;
    // a pointer write without the switch option is refused
    assign acc_ok = ((sel_cur || sel_lim) && sp_size_ok
                     && !(acc_write && sel_cur && !acc_switch))
                    || sel_st;

    // -----------------------------------------------------------------
    // merged write values
    // -----------------------------------------------------------------
    function automatic logic [47:0] merge48(input logic [47:0] old,
                                            input logic [63:0] wd,
                                            input logic [1:0]  sz,
                                            input logic        hi);
        logic [47:0] r;
        r = old;
        if (sz == tsr_pkg::SIZE_QWORD)
            r = wd[47:0];
        else if (hi)
            r[47:32] = wd[15:0];
        else
            r[31:0] = wd[31:0];
        return r;
    endfunction

    logic [47:0] sp_nxt;
    logic [47:0] lim_nxt;
    assign sp_nxt  = merge48(cur_sp_r, acc_wdata, acc_size, hi_dw);
    assign lim_nxt = merge48(limit_r, acc_wdata, acc_size, hi_dw);

    // -----------------------------------------------------------------
    // stack pointer and limit
    // -----------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            cur_sp_r <= tsr_pkg::RESET_ZERO64[47:0];
            flat_r   <= 1'b0;
            base_r   <= tsr_pkg::RESET_ZERO64[47:0];
        end
        else if (load_valid)
        begin
            cur_sp_r <= load_scratch_ptr + load_scratch_size
                        - tsr_pkg::ONE48;
            flat_r   <= load_flat;
            base_r   <= load_scratch_ptr;
        end
        else if (acc_valid && acc_write && acc_ok && sel_cur)
        begin
            cur_sp_r <= sp_nxt;
            flat_r   <= acc_flat;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            limit_r <= tsr_pkg::RESET_ZERO64[47:0];
        else if (load_valid)
            limit_r <= load_scratch_ptr + load_stack_limit;
        else if (acc_valid && acc_write && acc_ok && sel_lim)
            limit_r <= lim_nxt;   // taken as given, no correction
    end

    // -----------------------------------------------------------------
    // thread state words, byte granular
    // -----------------------------------------------------------------
    genvar gw;
    generate
        for (gw = 0; gw < tsr_pkg::ST_WORDS; gw++)
        begin : g_st
            always_ff @(posedge mclk)
            begin
                if (reset)
                    st_r[gw] <= tsr_pkg::RESET_ZERO32;
                else if (load_valid)
                    st_r[gw] <= load_state[gw*32 +: 32];
                else if (acc_valid && acc_write && sel_st
                         && st_idx == 2'(gw))
                begin
                    if (acc_size == tsr_pkg::SIZE_BYTE)
                        st_r[gw][st_byte*8 +: 8] <= acc_wdata[7:0];
                    else
                        st_r[gw] <= acc_wdata[31:0];
                end
            end
        end
    endgenerate

    // -----------------------------------------------------------------
    // read path, reserved bits as zero
    // -----------------------------------------------------------------
    logic [47:0] rd48;
    logic [63:0] rd_nxt;
    always_comb
    begin
        rd48   = sel_lim ? limit_r : cur_sp_r;
        rd_nxt = tsr_pkg::RESET_ZERO64;
        if (sel_st)
        begin
            if (acc_size == tsr_pkg::SIZE_BYTE)
                rd_nxt[7:0] = st_r[st_idx][st_byte*8 +: 8];
            else
                rd_nxt[31:0] = st_r[st_idx];
        end
        else if (acc_size == tsr_pkg::SIZE_QWORD)
            rd_nxt = {tsr_pkg::RSVD_MBZ, rd48};
        else if (hi_dw)
            rd_nxt[31:0] = {tsr_pkg::RSVD_MBZ, rd48[47:32]};
        else
            rd_nxt[31:0] = rd48[31:0];
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            acc_rdata  <= tsr_pkg::RESET_ZERO64;
            acc_rvalid <= 1'b0;
            acc_error  <= 1'b0;
        end
        else
        begin
            acc_rdata  <= (acc_valid && !acc_write && acc_ok)
                          ? rd_nxt : tsr_pkg::RESET_ZERO64;
            acc_rvalid <= acc_valid && !acc_write && acc_ok;
            acc_error  <= acc_valid && !acc_ok;
        end
    end

    // -----------------------------------------------------------------
    // message header insertion
    // -----------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            msg_sp       <= tsr_pkg::RESET_ZERO64[47:0];
            msg_sp_valid <= 1'b0;
            msg_sp_flat  <= 1'b0;
        end
        else
        begin
            msg_sp       <= stk_store ? cur_sp_r
                                      : tsr_pkg::RESET_ZERO64[47:0];
            msg_sp_valid <= stk_store;
            msg_sp_flat  <= stk_store && flat_r;
        end
    end

    // -----------------------------------------------------------------
    // exception: level, held while pointer is out of range
    // -----------------------------------------------------------------
    // flat stacks have no known allocation, so only the limit is checked
    always_ff @(posedge mclk)
    begin
        if (reset)
            sp_exception <= 1'b0;
        else
            sp_exception <= (cur_sp_r > limit_r)
                            || (!flat_r && cur_sp_r < base_r);
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    AST_LOAD_SP: assert property (@(posedge mclk) disable iff (reset)
        load_valid |=> cur_sp_r == $past(load_scratch_ptr)
            + $past(load_scratch_size) - tsr_pkg::ONE48)
        else $error("stack pointer not loaded as top of scratch");
    AST_LOAD_LIM: assert property (@(posedge mclk) disable iff (reset)
        load_valid |=> limit_r == $past(load_scratch_ptr)
            + $past(load_stack_limit))
        else $error("stack limit not loaded");
    AST_MSG_SP: assert property (@(posedge mclk) disable iff (reset)
        stk_store |=> msg_sp_valid && msg_sp == $past(cur_sp_r))
        else $error("header stack pointer wrong");
    AST_EXC: assert property (@(posedge mclk) disable iff (reset)
        (cur_sp_r > limit_r) |=> sp_exception)
        else $error("missing stack exception");
    AST_NOSWITCH: assert property (@(posedge mclk) disable iff (reset)
        (acc_valid && acc_write && is_sp && !acc_switch && !load_valid
         && acc_subreg == tsr_pkg::SUB_CUR_SP)
        |=> cur_sp_r == $past(cur_sp_r) && acc_error)
        else $error("write without switch accepted");
    AST_RSVD: assert property (@(posedge mclk) disable iff (reset)
        acc_rvalid && $past(acc_size) == tsr_pkg::SIZE_QWORD
        |-> acc_rdata[63:48] == tsr_pkg::RSVD_MBZ)
        else $error("reserved bits not zero");
    AST_QW_WR: assert property (@(posedge mclk) disable iff (reset)
        (acc_valid && acc_write && acc_ok && sel_lim && !load_valid
         && acc_size == tsr_pkg::SIZE_QWORD)
        |=> limit_r == $past(acc_wdata[47:0]))
        else $error("qword limit write lost");
    AST_BAD_SUB: assert property (@(posedge mclk) disable iff (reset)
        (acc_valid && is_sp && acc_subreg[4]) |=> acc_error)
        else $error("reserved subregister accepted");
    AST_ST_BYTE: assert property (@(posedge mclk) disable iff (reset)
        (acc_valid && acc_write && is_st && !load_valid && !acc_subreg[4]
         && acc_size == tsr_pkg::SIZE_BYTE)
        |=> st_r[$past(st_idx)][$past(st_byte)*8 +: 8]
            == $past(acc_wdata[7:0]))
        else $error("state byte write lost");
    AST_TYPE: assert property (@(posedge mclk) disable iff (reset)
        (acc_valid && !is_sp && !is_st) |=> acc_error)
        else $error("foreign register type accepted");

endmodule

// File: design/tsr_pkg.sv
package tsr_pkg;

    // -----------------------------------------------------------------
    // architecture register addressing
    // -----------------------------------------------------------------
    localparam logic [3:0] TYPE_STACK_PTR   = 4'h6;
    localparam logic [3:0] TYPE_THREAD_ST   = 4'h7;
    localparam logic [3:0] REGNUM_ZERO      = 4'h0;
    localparam logic [4:0] SUB_CUR_SP       = 5'h00;
    localparam logic [4:0] SUB_LIMIT        = 5'h08;
    localparam logic [4:0] SUB_ST_WORD0     = 5'h00;
    localparam logic [4:0] SUB_ST_WORD1     = 5'h04;
    localparam logic [4:0] SUB_ST_WORD2     = 5'h08;
    localparam logic [4:0] SUB_ST_WORD3     = 5'h0C;
    localparam logic [1:0] SUB_DW_HI_POS    = 2'h2;

    // -----------------------------------------------------------------
    // field layout and widths
    // -----------------------------------------------------------------
    localparam int         ADDR_W           = 48;
    localparam int         ST_WORDS         = 4;
    localparam logic [63:0] RESET_ZERO64    = 64'h0000_0000_0000_0000;
    localparam logic [31:0] RESET_ZERO32    = 32'h0000_0000;
    localparam logic [15:0] RSVD_MBZ        = 16'h0000;
    localparam logic [47:0] ONE48           = 48'h0000_0000_0001;

    // access sizes
    localparam logic [1:0] SIZE_DWORD       = 2'h0;
    localparam logic [1:0] SIZE_QWORD       = 2'h1;
    localparam logic [1:0] SIZE_BYTE        = 2'h2;

endpackage

// File: sim/tsr_disp_model.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------------
// dispatcher side: hands one thread load to the register file
// ---------------------------------------------------------------------
module tsr_disp_model
(
    // clock
    input  wire logic         mclk,
    // thread load
    output logic              load_valid,
    output logic      [47:0]  load_scratch_ptr,
    output logic      [47:0]  load_scratch_size,
    output logic      [47:0]  load_stack_limit,
    output logic      [127:0] load_state,
    output logic              load_flat
);
    initial
    begin
        load_valid = 1'b0;
        load_scratch_ptr = '0;
        load_scratch_size = '0;
        load_stack_limit = '0;
        load_state = '0;
        load_flat = 1'b0;
    end

    // called at a falling edge; operands turn over once the pulse is gone
    // so a late sample sees garbage rather than the last value
    task automatic dispatch(input logic [47:0] p, input logic [47:0] s,
                            input logic [47:0] l, input logic [127:0] st,
                            input logic fl);
        load_valid = 1'b1;
        load_scratch_ptr = p;
        load_scratch_size = s;
        load_stack_limit = l;
        load_state = st;
        load_flat = fl;
        @(posedge mclk);
        @(negedge mclk);
        load_valid = 1'b0;
        load_scratch_ptr = ~p;
        load_scratch_size = ~s;
        load_stack_limit = ~l;
        load_state = ~st;
        load_flat = ~fl;
    endtask
endmodule

// File: sim/tsr_regs_tb.sv
`timescale 1ns/1ps

module tsr_regs_tb;
    logic         mclk, reset, load_valid, load_flat, acc_valid, acc_write;
    logic [47:0]  load_scratch_ptr, load_scratch_size, load_stack_limit;
    logic [127:0] load_state;
    logic [7:0]   acc_regnum;
    logic [4:0]   acc_subreg;
    logic [1:0]   acc_size;
    logic [63:0]  acc_wdata, acc_rdata;
    logic         acc_switch, acc_flat, acc_rvalid, acc_error, stk_store;
    logic [47:0]  msg_sp;
    logic         msg_sp_valid, msg_sp_flat, sp_exception;
    int           mismatches, cmp_count;
    logic [31:0]  lfsr_r;
    // reference state
    logic [47:0]  m_sp, m_lim, m_base;
    logic [127:0] m_st;
    logic         m_flat;
    logic [7:0]   tv [4] = '{8'h60, 8'h70, 8'h61, 8'h50};
    logic [31:0]  r;

    tsr_regs i_tsr_regs (.mclk(mclk), .reset(reset), .load_valid(load_valid),
        .load_scratch_ptr(load_scratch_ptr), .load_flat(load_flat),
        .load_scratch_size(load_scratch_size), .load_state(load_state),
        .load_stack_limit(load_stack_limit), .acc_valid(acc_valid),
        .acc_write(acc_write), .acc_regnum(acc_regnum), .acc_size(acc_size),
        .acc_subreg(acc_subreg), .acc_wdata(acc_wdata), .acc_flat(acc_flat),
        .acc_switch(acc_switch), .acc_rdata(acc_rdata), .msg_sp(msg_sp),
        .acc_rvalid(acc_rvalid), .acc_error(acc_error), .stk_store(stk_store),
        .msg_sp_valid(msg_sp_valid), .msg_sp_flat(msg_sp_flat),
        .sp_exception(sp_exception));

    tsr_disp_model i_tsr_disp_model (.mclk(mclk), .load_valid(load_valid),
        .load_scratch_ptr(load_scratch_ptr), .load_flat(load_flat),
        .load_scratch_size(load_scratch_size), .load_state(load_state),
        .load_stack_limit(load_stack_limit));

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        lfsr_r = {lfsr_r[30:0],
                  lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
        return lfsr_r;
    endfunction

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // every task starts and ends at a falling edge
    task automatic acc(input logic w, input logic [7:0] rn,
                       input logic [4:0] sr,
                       input logic [1:0] sz, input logic [63:0] wd,
                       input logic sw, input logic fl);
        logic        err;
        logic [47:0] v;
        logic [63:0] rd;
        int          b;
        acc_valid = 1'b1;
        acc_write = w;
        acc_regnum = rn;
        acc_subreg = sr;
        acc_size = sz;
        acc_wdata = wd;
        acc_switch = sw;
        acc_flat = fl;
        rd = '0;
        v = sr[3] ? m_lim : m_sp;
        b = 32 * sr[3:2] + 8 * sr[1:0];
        if (rn == {tsr_pkg::TYPE_STACK_PTR, tsr_pkg::REGNUM_ZERO})
        begin
            err = sz == tsr_pkg::SIZE_BYTE || sr[4] || sr[1:0] != 2'h0
                || (sz == tsr_pkg::SIZE_QWORD && sr[2])
                || (w && !sr[3] && !sw);
            if (sz == tsr_pkg::SIZE_QWORD)
            begin
                rd = {16'h0000, v};
                v = wd[47:0];
            end
            else if (sr[2])
            begin
                rd = {48'h0000_0000_0000, v[47:32]};
                v[47:32] = wd[15:0];
            end
            else
            begin
                rd = {32'h0000_0000, v[31:0]};
                v[31:0] = wd[31:0];
            end
            if (w && !err && sr[3])
                m_lim = v;
            if (w && !err && !sr[3])
            begin
                m_sp = v;
                m_flat = fl;
            end
        end
        else if (rn == {tsr_pkg::TYPE_THREAD_ST, tsr_pkg::REGNUM_ZERO})
        begin
            err = sr[4] || (sz == tsr_pkg::SIZE_DWORD && sr[1:0] != 2'h0);
            if (sz == tsr_pkg::SIZE_BYTE)
                rd = {56'h0, m_st[b +: 8]};
            else
                rd = {32'h0000_0000, m_st[b +: 32]};
            if (w && !err && sz == tsr_pkg::SIZE_BYTE)
                m_st[b +: 8] = wd[7:0];
            else if (w && !err)
                m_st[b +: 32] = wd[31:0];
        end
        else
            err = 1'b1;
        if (w || err)
            rd = '0;
        @(posedge mclk);
        @(negedge mclk);
        chk(64'(acc_error), 64'(err));
        chk(64'(acc_rvalid), 64'(!w && !err));
        chk(acc_rdata, rd);
    endtask

    task automatic idle();
        logic exc;
        exc = m_sp > m_lim || (!m_flat && m_sp < m_base);
        acc_valid = 1'b0;
        stk_store = 1'b0;
        @(posedge mclk);
        @(negedge mclk);
        chk(64'(acc_rvalid), '0);
        chk(64'(acc_error), '0);
        chk(64'(msg_sp_valid), '0);
        chk(64'(sp_exception), 64'(exc));
    endtask

    task automatic stk();
        acc_valid = 1'b0;
        stk_store = 1'b1;
        @(posedge mclk);
        @(negedge mclk);
        chk(64'(msg_sp_valid), 64'h1);
        chk(64'(msg_sp), 64'(m_sp));
        chk(64'(msg_sp_flat), 64'(m_flat));
    endtask

    task automatic load(input logic [47:0] p, input logic [47:0] s,
                        input logic [47:0] l, input logic fl);
        logic [127:0] st;
        st = {rnd(), rnd(), rnd(), rnd()};
        i_tsr_disp_model.dispatch(p, s, l, st, fl);
        m_sp = p + s - tsr_pkg::ONE48;
        m_lim = p + l;
        m_base = p;
        m_st = st;
        m_flat = fl;
        for (int k = 0; k < 2; k++)
            acc(1'b0, 8'h60, 5'(8 * k), tsr_pkg::SIZE_QWORD, '0, 1'b0, 1'b0);
        for (int k = 0; k < 4; k++)
            acc(1'b0, 8'h70, 5'(4 * k), tsr_pkg::SIZE_DWORD, '0, 1'b0, 1'b0);
        stk();
        idle();
    endtask

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial
    begin
        {reset, acc_valid, acc_write, acc_switch, acc_flat, stk_store} = 6'h2e;
        {acc_regnum, acc_subreg, acc_size, acc_wdata} = '0;
        {m_sp, m_lim, m_base, m_st, m_flat} = '0;
        mismatches = 0;
        cmp_count = 0;
        lfsr_r = 32'h0001_2AF8;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        reset = 1'b0;
        @(negedge mclk);
        acc(1'b0, 8'h60, 5'h08, tsr_pkg::SIZE_QWORD, '0, 1'b0, 1'b0);
        idle();
        $display("test reset done");
        load(48'h0000_1000_0000, 48'h0000_0000_2000, 48'h0000_0000_4000, 1'b0);
        load(48'hFFFF_FFFF_F000, 48'h0000_0000_2000, 48'h0000_0000_1000, 1'b0);
        load(48'h0000_0040_0000, 48'h0000_0000_0100, 48'h0000_0000_0080, 1'b1);
        $display("test load done");
        // pointer writes without the switch option must be refused
        r = rnd();
        acc(1'b1, 8'h60, 5'h00, tsr_pkg::SIZE_QWORD, {rnd(), r}, 1'b0, r[4]);
        acc(1'b1, 8'h60, 5'h04, tsr_pkg::SIZE_DWORD, {rnd(), r}, 1'b0, r[4]);
        acc(1'b0, 8'h60, 5'h00, tsr_pkg::SIZE_QWORD, '0, 1'b0, 1'b0);
        idle();
        $display("test switch done");
        // random writes and read-backs over the four register numbers in tv, every offset and size except qword access to the thread state
        for (int t = 0; t < 4; t++)
            for (int sr = 0; sr < 32; sr++)
                for (int sz = 0; sz < 3; sz++)
                    if (!(t == 1 && sz == 1))
                    begin
                        r = rnd();
                        acc(1'b1, tv[t], 5'(sr), 2'(sz), {rnd(), r},
                            r[3:0] != 4'h0, r[4]);
                        acc(1'b0, tv[t], 5'(sr), 2'(sz), '0, 1'b0, 1'b0);
                        if (sr[2:0] == 3'h0)
                            stk();
                        idle();
                    end
        $display("test sweep done");
        // registers must come back to zero from a reset in mid-run
        reset = 1'b1;
        repeat (2) @(negedge mclk);
        reset = 1'b0;
        {m_sp, m_lim, m_base, m_st, m_flat} = '0;
        for (int k = 0; k < 4; k++)
            acc(1'b0, 8'h70, 5'(4 * k), tsr_pkg::SIZE_DWORD, '0, 1'b0, 1'b0);
        acc(1'b0, 8'h60, 5'h00, tsr_pkg::SIZE_QWORD, '0, 1'b0, 1'b0);
        acc(1'b0, 8'h60, 5'h08, tsr_pkg::SIZE_QWORD, '0, 1'b0, 1'b0);
        stk();
        idle();
        $display("test mid reset done");
        end_sim();
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        end_sim();
    end
endmodule
